// >>> core/fdsl_pkg.sv
/*
 * Shared constants for the floppy disk support logic: timing figures, derived
 * cycle counts and the positions of the pin inputs in the synchroniser vector.
 * Assumes a single core clock at CLK_HZ.
 */
package fdsl_pkg;
    // ==========================================================
    // Clock and timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int WCK_PERIOD_LO_NS = 2000;
    localparam int WCK_PERIOD_HI_NS = 1000;
    localparam int WCK_PULSE_NS = 250;
    localparam int DMA_DELAY_NS = 1000;
    localparam int PRECOMP_NS = 150;
    localparam int WCK_PERIOD_LO_CYC = (WCK_PERIOD_LO_NS * CLK_MHZ) / 1000;
    localparam int WCK_PERIOD_HI_CYC = (WCK_PERIOD_HI_NS * CLK_MHZ) / 1000;
    localparam int WCK_PULSE_CYC = (WCK_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int DMA_DELAY_CYC = (DMA_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int PRECOMP_CYC = (PRECOMP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 7;

    // ==========================================================
    // Pin input positions in the synchroniser vector.
    localparam int PIN_COUNT = 12;
    localparam int PIN_DENSITY = 0;
    localparam int PIN_RD_N = 1;
    localparam int PIN_STEP = 2;
    localparam int PIN_SEEK = 3;
    localparam int PIN_DRIVE_TRACK_ZERO_N = 4;
    localparam int PIN_WGATE = 5;
    localparam int PIN_WDATA = 6;
    localparam int PIN_PS_LOW = 7;
    localparam int PIN_PS_HIGH = 8;
    localparam int PIN_DRQ = 9;
    localparam int PIN_INT = 10;
    localparam int PIN_ENABLE = 11;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 12'h012;
endpackage

// >>> core/fdsl_pin_if.sv
/*
 * Carries the raw pin levels into the synchroniser and the settled levels
 * back to the core logic. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface fdsl_pin_if #(
    parameter int W = 12
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport core (output raw, input clean);
endinterface // fdsl_pin_if

// >>> core/fdsl_pin_sync.sv
/*
 * Three-stage synchroniser for every pin input; a new level is taken once
 * the second and third stages agree. Assumes synchronous active-high reset.
 */
`timescale 1ns/1ps
module fdsl_pin_sync #(
    parameter int W = 12,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    fdsl_pin_if.sync pins
);
    // ==========================================================
    // One synchroniser per pin.
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic clean_q;
        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
            begin
                s1_q <= IDLE[i];
                s2_q <= IDLE[i];
                s3_q <= IDLE[i];
                clean_q <= IDLE[i];
            end
            else
            begin
                s1_q <= pins.raw[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q)
                begin
                    clean_q <= s3_q;
                end
            end
        end
        assign pins.clean[i] = clean_q;
    end
endmodule // fdsl_pin_sync

// >>> core/fdsl_core.sv
/*
 * Floppy disk support logic: clock generation, read data separation, write
 * precompensation, step and track-zero routing, delayed DMA request and
 * interrupt forwarding. Assumes all inputs are asynchronous pins.
 */
//
// Overview of operation
// RQ1: With density select low the write clock gives one 250 ns pulse every 2 us.
// RQ2: With density select high the write clock gives one 250 ns pulse every 1 us.
// RQ3: The controller clock is the master clock divided by four at low density, by two at high.
// RQ4: Density select low means a low density drive and high a high density drive.
// RQ5: The delayed DMA request output follows the controller's request 1.0 us later.
// RQ6: Seek mode holds while the seek mode input is high, read/write mode while it is low.
// RQ7: Each step request pulse is passed to the drive step output to move the head; the code passes it only in seek mode.
// RQ8: The drive's active-low track-zero level is forwarded to the controller; the code forwards it only in seek mode and holds the output low otherwise.
// RQ9: While write gate is high, write data goes to the drive inverted and precompensated.
// RQ10: DMA request and interrupt reach their outputs only while the enable input is high.
// RQ11: Drive read pulses are separated into read data and a read data window.
`timescale 1ns/1ps
module fdsl_core
    import fdsl_pkg::*;
#(
    parameter int PRECOMP_SHIFT = fdsl_pkg::PRECOMP_CYC,
    parameter int DMA_DELAY = fdsl_pkg::DMA_DELAY_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic density_select_i,
    input wire logic drive_read_data_n_i,
    input wire logic step_request_i,
    input wire logic seek_mode_i,
    input wire logic drive_track_zero_n_i,
    input wire logic write_gate_i,
    input wire logic controller_write_data_i,
    input wire logic precomp_select_low_i,
    input wire logic precomp_select_high_i,
    input wire logic controller_dma_request_i,
    input wire logic controller_interrupt_i,
    input wire logic dma_interrupt_enable_i,
    output logic write_clock_o,
    output logic controller_clock_o,
    output logic separated_read_data_o,
    output logic read_window_o,
    output logic drive_step_n_o,
    output logic controller_track_zero_o,
    output logic drive_write_data_n_o,
    output logic delayed_dma_request_n_o,
    output logic disk_interrupt_out_o
);
    import fdsl_pkg::*;

    // ==========================================================
    // Parameter checks.
    if (PRECOMP_SHIFT < 1 || DMA_DELAY < 2)
    begin : g_bad_param
        $error("fdsl_core: precompensation or DMA delay too small");
    end

    // ==========================================================
    // Pin synchronisation.
    fdsl_pin_if #(.W(PIN_COUNT)) pins ();
    assign pins.raw = {dma_interrupt_enable_i, controller_interrupt_i,
                       controller_dma_request_i, precomp_select_high_i,
                       precomp_select_low_i, controller_write_data_i,
                       write_gate_i, drive_track_zero_n_i, seek_mode_i,
                       step_request_i, drive_read_data_n_i, density_select_i};

    fdsl_pin_sync #(.W(PIN_COUNT), .IDLE(PIN_IDLE)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pins(pins)
    );

    logic high_density;
    logic seek_mode;
    logic enable;
    assign high_density = pins.clean[PIN_DENSITY];
    assign seek_mode = pins.clean[PIN_SEEK];
    assign enable = pins.clean[PIN_ENABLE];

    // ==========================================================
    // Write clock.
    logic [CNT_W-1:0] wck_cnt_q;
    logic [CNT_W-1:0] wck_last;
    assign wck_last = high_density ? CNT_W'(WCK_PERIOD_HI_CYC - 1)
                                   : CNT_W'(WCK_PERIOD_LO_CYC - 1); // RQ4

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            wck_cnt_q <= '0;
            write_clock_o <= 1'b0;
        end
        else if (wck_cnt_q >= wck_last)
        begin
            wck_cnt_q <= '0; // RQ1 RQ2
            write_clock_o <= 1'b1;
        end
        else
        begin
            wck_cnt_q <= wck_cnt_q + 1'b1;
            write_clock_o <= write_clock_o && ((wck_cnt_q + 1'b1) < CNT_W'(WCK_PULSE_CYC)); // RQ1 RQ2
        end
    end

    // ==========================================================
    // Controller clock.
    logic div_q;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            div_q <= 1'b0;
            controller_clock_o <= 1'b0;
        end
        else
        begin
            div_q <= ~div_q;
            if (high_density || div_q)
            begin
                controller_clock_o <= ~controller_clock_o; // RQ3
            end
        end
    end

    // ==========================================================
    // Read data separator.
    logic rd_prev_q;
    logic rd_pulse;
    logic [CNT_W-1:0] win_cnt_q;
    logic [CNT_W-1:0] win_last;
    logic [CNT_W-1:0] sep_cnt_q;
    assign rd_pulse = rd_prev_q && !pins.clean[PIN_RD_N];
    assign win_last = high_density ? CNT_W'(WCK_PERIOD_HI_CYC / 2 - 1)
                                   : CNT_W'(WCK_PERIOD_LO_CYC / 2 - 1);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rd_prev_q <= 1'b1;
            win_cnt_q <= '0;
            read_window_o <= 1'b0;
        end
        else
        begin
            rd_prev_q <= pins.clean[PIN_RD_N];
            if (rd_pulse)
            begin
                win_cnt_q <= win_last >> 1; // RQ11
            end
            else if (win_cnt_q >= win_last)
            begin
                win_cnt_q <= '0;
                read_window_o <= ~read_window_o; // RQ11
            end
            else
            begin
                win_cnt_q <= win_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sep_cnt_q <= '0;
            separated_read_data_o <= 1'b0;
        end
        else if (rd_pulse)
        begin
            sep_cnt_q <= CNT_W'(WCK_PULSE_CYC - 1); // RQ11
            separated_read_data_o <= 1'b1;
        end
        else if (sep_cnt_q != '0)
        begin
            sep_cnt_q <= sep_cnt_q - 1'b1;
        end
        else
        begin
            separated_read_data_o <= 1'b0;
        end
    end

    // ==========================================================
    // Step and track zero.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            drive_step_n_o <= 1'b1;
            controller_track_zero_o <= 1'b0;
        end
        else
        begin
            drive_step_n_o <= !(seek_mode && pins.clean[PIN_STEP]); // RQ6 RQ7
            controller_track_zero_o <= seek_mode && !pins.clean[PIN_DRIVE_TRACK_ZERO_N]; // RQ6 RQ8
        end
    end

    // ==========================================================
    // Write data with precompensation.
    logic [2*PRECOMP_SHIFT:0] wd_hist_q;
    logic wd_tap;
    always_comb
    begin
        if (pins.clean[PIN_PS_LOW] && !pins.clean[PIN_PS_HIGH])
        begin
            wd_tap = wd_hist_q[0];
        end
        else if (pins.clean[PIN_PS_HIGH] && !pins.clean[PIN_PS_LOW])
        begin
            wd_tap = wd_hist_q[2*PRECOMP_SHIFT];
        end
        else
        begin
            wd_tap = wd_hist_q[PRECOMP_SHIFT];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            wd_hist_q <= '0;
            drive_write_data_n_o <= 1'b1;
        end
        else
        begin
            wd_hist_q <= {wd_hist_q[2*PRECOMP_SHIFT-1:0], pins.clean[PIN_WDATA]};
            drive_write_data_n_o <= !(pins.clean[PIN_WGATE] && wd_tap); // RQ9
        end
    end

    // ==========================================================
    // DMA request delay and interrupt gating.
    logic [DMA_DELAY-2:0] dly_q;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            dly_q <= '0;
            delayed_dma_request_n_o <= 1'b1;
            disk_interrupt_out_o <= 1'b0;
        end
        else
        begin
            dly_q <= {dly_q[DMA_DELAY-3:0], pins.clean[PIN_DRQ]}; // RQ5
            delayed_dma_request_n_o <= !(dly_q[DMA_DELAY-2] && enable); // RQ5 RQ10
            disk_interrupt_out_o <= pins.clean[PIN_INT] && enable; // RQ10
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic [CNT_W-1:0] gap_q;
    logic dens_rise_q;
    logic dens_steady_q;
    logic [1:0] run_q;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            run_q <= 2'h0;
        end
        else if (run_q != 2'h3)
        begin
            run_q <= run_q + 2'h1;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            gap_q <= '0;
            dens_rise_q <= 1'b0;
            dens_steady_q <= 1'b0;
        end
        else if (write_clock_o && !$past(write_clock_o))
        begin
            gap_q <= '0;
            dens_rise_q <= high_density;
            dens_steady_q <= 1'b1;
        end
        else
        begin
            gap_q <= gap_q + 1'b1;
            if (high_density != dens_rise_q)
            begin
                dens_steady_q <= 1'b0;
            end
        end
    end

    property p_wck_lo;
        $rose(write_clock_o) && dens_steady_q && !dens_rise_q && !high_density
            |-> gap_q == CNT_W'(WCK_PERIOD_LO_CYC - 1);
    endproperty
    a_wck_lo: assert property (p_wck_lo) else $error("low density write clock period wrong"); // RQ1

    property p_wck_hi;
        $rose(write_clock_o) && dens_steady_q && dens_rise_q && high_density
            |-> gap_q == CNT_W'(WCK_PERIOD_HI_CYC - 1);
    endproperty
    a_wck_hi: assert property (p_wck_hi) else $error("high density write clock period wrong"); // RQ2

    property p_wck_width;
        $rose(write_clock_o) |-> write_clock_o[*5] ##1 !write_clock_o;
    endproperty
    a_wck_width: assert property (p_wck_width) else $error("write clock pulse width wrong"); // RQ1 RQ2

    property p_fcc_div;
        (high_density && $past(high_density)) |-> controller_clock_o != $past(controller_clock_o);
    endproperty
    a_fcc_div: assert property (p_fcc_div) else $error("controller clock not divided by two"); // RQ3 RQ4

    property p_fcc_div4;
        (run_q >= 2'h2 && !high_density && $past(!high_density) && $past(!high_density, 2))
            |-> controller_clock_o != $past(controller_clock_o, 2);
    endproperty
    a_fcc_div4: assert property (p_fcc_div4) else $error("controller clock not divided by four"); // RQ3 RQ4

    property p_dma_delay;
        $rose(pins.clean[PIN_DRQ]) |-> ##20 (!delayed_dma_request_n_o || !$past(enable));
    endproperty
    a_dma_delay: assert property (p_dma_delay) else $error("DMA request delay wrong"); // RQ5

    property p_step;
        (seek_mode && pins.clean[PIN_STEP]) |=> !drive_step_n_o;
    endproperty
    a_step: assert property (p_step) else $error("step request not forwarded"); // RQ7

    property p_rw_mode;
        !seek_mode |=> drive_step_n_o && !controller_track_zero_o;
    endproperty
    a_rw_mode: assert property (p_rw_mode) else $error("step or track zero active in read/write mode"); // RQ6

    property p_drive_track_zero;
        (seek_mode && !pins.clean[PIN_DRIVE_TRACK_ZERO_N]) |=> controller_track_zero_o;
    endproperty
    a_drive_track_zero: assert property (p_drive_track_zero) else $error("track zero not forwarded"); // RQ8

    property p_wgate;
        !pins.clean[PIN_WGATE] |=> drive_write_data_n_o;
    endproperty
    a_wgate: assert property (p_wgate) else $error("write data driven without write gate"); // RQ9

    property p_enable;
        !enable |=> delayed_dma_request_n_o && !disk_interrupt_out_o;
    endproperty
    a_enable: assert property (p_enable) else $error("request passed while disabled"); // RQ10

    property p_sep;
        rd_pulse |=> separated_read_data_o[*5];
    endproperty
    a_sep: assert property (p_sep) else $error("separated read data pulse too short"); // RQ11
endmodule // fdsl_core

// >>> tb/fdsl_far_end.sv
/*
 * Far-side model: a drive head that steps towards cylinder zero and sends
 * read pulses on request. Assumes the bench clock and the support logic outputs.
 */
`timescale 1ns/1ps
module fdsl_far_end (
    input wire logic core_clk_i,
    input wire logic drive_step_n_i,
    input wire logic read_pulse_req_i,
    output logic drive_read_data_n_o,
    output logic drive_track_zero_n_o
);
    // ==========================================================
    // Head position and read pulses.
    int cyl_q = 2;
    int rd_cnt_q = 0;
    logic step_n_q = 1'b1;
    always_ff @(posedge core_clk_i)
    begin
        step_n_q <= drive_step_n_i;
        if (step_n_q === 1'b1 && drive_step_n_i === 1'b0 && cyl_q > 0)
        begin
            cyl_q <= cyl_q - 1;
        end
        if (read_pulse_req_i)
        begin
            rd_cnt_q <= 3;
        end
        else if (rd_cnt_q > 0)
        begin
            rd_cnt_q <= rd_cnt_q - 1;
        end
    end
    assign drive_track_zero_n_o = (cyl_q != 0);
    assign drive_read_data_n_o = (rd_cnt_q == 0);
endmodule // fdsl_far_end

// >>> tb/floppy_disk_support_logic_test.sv
/*
 * Self-checking bench for the floppy disk support logic core.
 * Assumes the far-side model and a 20 MHz core clock.
 */
`timescale 1ns/1ps
module floppy_disk_support_logic_test;
    // ==========================================================
    // Signals.
    typedef struct {logic dens; int wck_per; int fck_per; int rdw_hi;} fdsl_row_type;
    localparam logic [8:0] RST_EXP = 9'h058;
    fdsl_row_type rows[2] = '{'{1'b0, 40, 4, 20}, '{1'b1, 20, 2, 10}};
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic density_select_i = 1'b0;
    logic step_request_i = 1'b0;
    logic seek_mode_i = 1'b0;
    logic write_gate_i = 1'b0;
    logic controller_write_data_i = 1'b0;
    logic precomp_select_low_i = 1'b0;
    logic precomp_select_high_i = 1'b0;
    logic controller_dma_request_i = 1'b0;
    logic controller_interrupt_i = 1'b0;
    logic dma_interrupt_enable_i = 1'b0;
    logic rd_req = 1'b0;
    logic rd_n, drive_track_zero_n, write_clock, fck, separated_read_data, read_window, step_n, ctz, wd_n, dma_n, irq;
    int error_cnt = 0;
    int samples_checked = 0;
    int n, hi, per, e;

    fdsl_core DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .density_select_i(density_select_i), .drive_read_data_n_i(rd_n),
        .step_request_i(step_request_i), .seek_mode_i(seek_mode_i),
        .drive_track_zero_n_i(drive_track_zero_n), .write_gate_i(write_gate_i),
        .controller_write_data_i(controller_write_data_i),
        .precomp_select_low_i(precomp_select_low_i),
        .precomp_select_high_i(precomp_select_high_i),
        .controller_dma_request_i(controller_dma_request_i),
        .controller_interrupt_i(controller_interrupt_i),
        .dma_interrupt_enable_i(dma_interrupt_enable_i), .write_clock_o(write_clock),
        .controller_clock_o(fck), .separated_read_data_o(separated_read_data), .read_window_o(read_window),
        .drive_step_n_o(step_n), .controller_track_zero_o(ctz),
        .drive_write_data_n_o(wd_n), .delayed_dma_request_n_o(dma_n),
        .disk_interrupt_out_o(irq));
    fdsl_far_end far (.core_clk_i(core_clk_i), .drive_step_n_i(step_n),
        .read_pulse_req_i(rd_req), .drive_read_data_n_o(rd_n),
        .drive_track_zero_n_o(drive_track_zero_n));

    initial
    begin
        forever #25 core_clk_i = ~core_clk_i;
    end

    // ==========================================================
    // Helpers.
    function automatic logic pick(input int k);
        logic [8:0] v;
        v = {irq, separated_read_data, wd_n, ctz, step_n, dma_n, read_window, fck, write_clock};
        return v[k];
    endfunction
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp_cnt(input int got, input int lo, input int up, input string what);
        samples_checked++;
        if (got < lo || got > up)
        begin
            error_cnt++;
            $display("ERROR at %0t: %s got %0d, expected %0d..%0d", $time, what, got, lo, up);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: %s got %b, expected %b", $time, what, got, exp);
        end
    endtask
    task automatic wait_lvl(input int k, input logic v, input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge core_clk_i);
            #1;
            cnt++;
        end
        while (pick(k) !== v && cnt < lim);
        if (pick(k) !== v)
        begin
            error_cnt++;
            $display("ERROR at %0t: wait on output %0d timed out", $time, k);
            summarize();
        end
    endtask
    task automatic meas(input int k, output int h, output int p);
        int m;
        wait_lvl(k, 1'b0, 100, m);
        wait_lvl(k, 1'b1, 100, m);
        wait_lvl(k, 1'b0, 100, h);
        wait_lvl(k, 1'b1, 100, m);
        p = h + m;
    endtask
    task automatic chk_rst();
        for (int k = 0; k < 9; k++)
        begin
            cmp_bit(pick(k), RST_EXP[k], "reset level");
        end
    endtask

    // ==========================================================
    // Sequence.
    initial
    begin
        repeat (12) @(posedge core_clk_i);
        #1;
        chk_rst();
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        $display("Test reset done");
        foreach (rows[i])
        begin
            @(posedge core_clk_i);
            density_select_i <= rows[i].dens;
            repeat (50) @(posedge core_clk_i);
            meas(0, hi, per);
            cmp_cnt(hi, 5, 5, "write clock high");
            cmp_cnt(per, rows[i].wck_per, rows[i].wck_per, "write clock period");
            meas(1, hi, per);
            cmp_cnt(per, rows[i].fck_per, rows[i].fck_per, "controller clock period");
            cmp_cnt(hi, rows[i].fck_per / 2, rows[i].fck_per / 2, "controller clock high");
            meas(2, hi, per);
            cmp_cnt(hi, rows[i].rdw_hi, rows[i].rdw_hi, "read window half");
            $display("Test density row %0d done", i);
        end
        @(posedge core_clk_i);
        dma_interrupt_enable_i <= 1'b1;
        controller_interrupt_i <= 1'b1;
        wait_lvl(8, 1'b1, 20, n);
        cmp_cnt(n, 4, 6, "interrupt latency");
        @(posedge core_clk_i);
        controller_dma_request_i <= 1'b1;
        wait_lvl(3, 1'b0, 40, n);
        cmp_cnt(n, 24, 26, "dma request delay");
        @(posedge core_clk_i);
        dma_interrupt_enable_i <= 1'b0;
        wait_lvl(8, 1'b0, 10, n);
        wait_lvl(3, 1'b1, 10, n);
        repeat (40) @(posedge core_clk_i);
        #1;
        cmp_bit(dma_n, 1'b1, "dma while disabled");
        cmp_bit(irq, 1'b0, "interrupt while disabled");
        $display("Test dma and interrupt done");
        @(posedge core_clk_i);
        step_request_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        #1;
        cmp_bit(step_n, 1'b1, "step in read/write mode");
        step_request_i <= 1'b0;
        seek_mode_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        #1;
        cmp_bit(ctz, 1'b0, "track zero off cylinder 0");
        repeat (2)
        begin
            @(posedge core_clk_i);
            step_request_i <= 1'b1;
            wait_lvl(4, 1'b0, 10, n);
            cmp_cnt(n, 4, 6, "step latency");
            @(posedge core_clk_i);
            step_request_i <= 1'b0;
            wait_lvl(4, 1'b1, 10, n);
        end
        wait_lvl(5, 1'b1, 10, n);
        @(posedge core_clk_i);
        seek_mode_i <= 1'b0;
        wait_lvl(5, 1'b0, 10, n);
        $display("Test step and track zero done");
        @(posedge core_clk_i);
        controller_write_data_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        #1;
        cmp_bit(wd_n, 1'b1, "write data without gate");
        controller_write_data_i <= 1'b0;
        write_gate_i <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            @(posedge core_clk_i);
            {precomp_select_high_i, precomp_select_low_i} <= p[1:0];
            repeat (10) @(posedge core_clk_i);
            controller_write_data_i <= 1'b1;
            wait_lvl(6, 1'b0, 20, n);
            e = (p == 1) ? 6 : (p == 2) ? 12 : 9;
            cmp_cnt(n, e - 1, e + 1, "write data latency");
            @(posedge core_clk_i);
            controller_write_data_i <= 1'b0;
            wait_lvl(6, 1'b1, 20, n);
        end
        $display("Test write data done");
        @(posedge core_clk_i);
        rd_req <= 1'b1;
        @(posedge core_clk_i);
        rd_req <= 1'b0;
        wait_lvl(7, 1'b1, 20, n);
        wait_lvl(7, 1'b0, 20, hi);
        cmp_cnt(hi, 5, 5, "read data width");
        $display("Test read data done");
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk_rst();
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_rst();
        $display("Test second reset done");
        summarize();
    end
endmodule // floppy_disk_support_logic_test
